// [shared/pma_params.svh]
`ifndef PMA_PARAMS_SVH
`define PMA_PARAMS_SVH
// Array geometry
`define PMA_NCELL 8
`define PMA_TPC 9
`define PMA_NLOGIC 8
`define PMA_NTERM 74
`define PMA_NSIG 18
`define PMA_NCOL 36
`define PMA_SP_TERM 72
`define PMA_AR_TERM 73
`define PMA_TSEL_W 7
// Byte offsets of the software registers
`define PMA_OFS_CTRL 12'h000
`define PMA_OFS_MODE 12'h004
`define PMA_OFS_TSEL 12'h008
`define PMA_OFS_TLO 12'h00C
`define PMA_OFS_THI 12'h010
`define PMA_OFS_PRELOAD 12'h014
`define PMA_OFS_STATUS 12'h018
// Control register fields
`define PMA_CTRL_GLOB 0
`define PMA_CTRL_SECURE 1
`define PMA_CTRL_ERASE 2
// Mode register field bases
`define PMA_MODE_A_LSB 0
`define PMA_MODE_B_LSB 8
`define PMA_POL_LSB 16
// Mode codes as {mode_bit_a, mode_bit_b}
`define PMA_MODE_REG 2'h3
`define PMA_MODE_BIDIR 2'h0
`define PMA_MODE_FIN 2'h1
`define PMA_MODE_FOUT 2'h2
// Unprogrammed values
`define PMA_MODE_RST 8'h00
`define PMA_POL_RST 8'hFF
`define PMA_GLOB_RST 1'h1
`endif

// [shared/pma_pkg.sv]
`include "pma_params.svh"
package pma_pkg;
   // Registered APB answer
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pma_apb_rsp_t;
   // Whole state of the array block
   typedef struct packed {
      logic [`PMA_NTERM-1:0][`PMA_NCOL-1:0] fuse;
      logic [`PMA_NCELL-1:0] mode_a;
      logic [`PMA_NCELL-1:0] mode_b;
      logic [`PMA_NCELL-1:0] pol;
      logic glob;
      logic secure;
      logic [`PMA_TSEL_W-1:0] term_sel;
      logic [`PMA_NCELL-1:0] cell_reg;
      logic [`PMA_NSIG-1:0] sy1;
      logic [`PMA_NSIG-1:0] sy2;
      logic [`PMA_NSIG-1:0] sy3;
      logic [`PMA_NSIG-1:0] filt;
      logic clk_prev;
      logic [`PMA_NCELL-1:0] pin_o;
      logic [`PMA_NCELL-1:0] pin_oe;
      pma_apb_rsp_t rsp;
   } pma_state_t;
endpackage

// [src/pma_top.sv]
// Notes on behaviour
// [RULE_01] Eight output cells, each configured on its own.
// [RULE_02] The AND plane gives 72 product terms, nine per cell.
// [RULE_03] Eight terms form each cell's function; the ninth gates its pin driver.
// [RULE_04] Two shared terms give synchronous preset and asynchronous reset.
// [RULE_05] Each cell has its own pair of mode bits, sixteen in all.
// [RULE_06] Each cell has one bit choosing inverted or true output.
// [RULE_07] Mode bits: 11 registered, 00 bidirectional, 01 input, 10 output.
// [RULE_08] Registered cells use the shared clock pin and shared enable pin.
// [RULE_09] Bidirectional driver is gated only by the cell's direction term.
// [RULE_10] Fixed output drives the pin but feeds nothing back.
// [RULE_11] Global cell low: clock and low enable; high: two plain inputs.
// [RULE_12] Registered cell enable comes only from the shared enable pin.
// [RULE_13] Configuring software sets the global cell low whenever a cell is registered.
// [RULE_14] Registered cell is a D flip-flop fed back into the array.
// [RULE_15] All cell registers clear at power-up.
// [RULE_16] Cell registers can be loaded directly with chosen values.
// [RULE_17] Security fuse blocks readout of the programmed configuration.
// [RULE_18] Unprogrammed: terms are 0, outputs invert, shared pins are inputs.
// [RULE_19] Unprogrammed: all cells bidirectional with drivers off.
// [RULE_20] Up to eighteen logic inputs reach the array.
// [RULE_21] Registers sample on the shared clock rising edge.
// [RULE_22] Cell value is OR of eight terms XOR polarity bit.
// [RULE_23] Async reset term clears at once; preset sets at next clock edge.
`timescale 1ns/10ps
`default_nettype none
module pma_top
   import pma_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic shared_clk_pin_i,
   input wire logic shared_oe_n_pin_i,
   input wire logic [7:0] ded_pin_i,
   input wire logic [`PMA_NCELL-1:0] cell_pin_i,
   output logic [`PMA_NCELL-1:0] cell_pin_o,
   output logic [`PMA_NCELL-1:0] cell_pin_oe_o
);

   pma_state_t q;
   pma_state_t d;

   logic [`PMA_NSIG-1:0] sig;
   logic [`PMA_NCOL-1:0] lits;
   logic [`PMA_NTERM-1:0] term;
   logic [`PMA_NCELL-1:0] sum;
   logic [`PMA_NCELL-1:0] dir;
   logic [`PMA_NCELL-1:0] fb;
   logic [`PMA_NCELL-1:0] oe_nx;
   logic [`PMA_NCELL-1:0] reg_mode;
   logic [`PMA_NSIG-1:0] pin_raw;
   logic ar_t;
   logic sp_t;
   logic clk_edge;
   logic acc;
   logic wr_go;
   logic preload_wr;
   logic erase_wr;
   logic tsel_ok;
   logic [11:0] ofs;

   // Raw pin vector: dedicated, clock/input, enable/input, cell pins
   assign pin_raw = {cell_pin_i, shared_oe_n_pin_i, shared_clk_pin_i, ded_pin_i};

   // Array signals; shared pins read as 0 while they serve clock and enable
   assign sig[7:0] = q.filt[7:0]; // [RULE_20]
   assign sig[8] = q.glob & q.filt[8]; // [RULE_11]
   assign sig[9] = q.glob & q.filt[9]; // [RULE_11]
   assign sig[17:10] = fb; // [RULE_20]

   // True and complement column per array signal
   for (genvar k = 0; k < `PMA_NSIG; k++)
   begin : g_lit
      assign lits[2*k] = sig[k];
      assign lits[2*k+1] = ~sig[k];
   end

   // Product terms; an intact fuse connects its column, so erased terms are 0
   for (genvar t = 0; t < `PMA_NTERM; t++)
   begin : g_term
      assign term[t] = &(~q.fuse[t] | lits); // [RULE_02] [RULE_18]
   end

   // Per-cell sum, direction term, feedback and next driver enable
   for (genvar n = 0; n < `PMA_NCELL; n++)
   begin : g_cell
      logic [1:0] mode;
      assign mode = {q.mode_a[n], q.mode_b[n]}; // [RULE_05] [RULE_01]
      assign reg_mode[n] = (mode == `PMA_MODE_REG);
      // Eight logic terms ORed, then polarity applied
      assign sum[n] = (|term[`PMA_TPC*n +: `PMA_NLOGIC]) ^ q.pol[n]; // [RULE_22] [RULE_06]
      assign dir[n] = term[`PMA_TPC*n + `PMA_NLOGIC]; // [RULE_03]
      // Feedback: register state, pin, or nothing for fixed outputs
      always_comb
      begin
         unique case (mode) // [RULE_07]
            `PMA_MODE_REG: fb[n] = q.cell_reg[n]; // [RULE_14]
            `PMA_MODE_FOUT: fb[n] = 1'h0; // [RULE_10]
            `PMA_MODE_FIN: fb[n] = q.filt[10+n];
            `PMA_MODE_BIDIR: fb[n] = q.filt[10+n];
         endcase
      end
      // Driver enable by mode
      always_comb
      begin
         unique case (mode)
            `PMA_MODE_REG: oe_nx[n] = ~q.glob & ~q.filt[9]; // [RULE_08] [RULE_12]
            `PMA_MODE_FOUT: oe_nx[n] = 1'h1; // [RULE_10]
            `PMA_MODE_FIN: oe_nx[n] = 1'h0;
            `PMA_MODE_BIDIR: oe_nx[n] = dir[n]; // [RULE_09] [RULE_19]
         endcase
      end
   end

   // Shared terms and the clock edge seen on the shared pin
   assign sp_t = term[`PMA_SP_TERM]; // [RULE_04]
   assign ar_t = term[`PMA_AR_TERM]; // [RULE_04]
   assign clk_edge = ~q.glob & q.filt[8] & ~q.clk_prev; // [RULE_21] [RULE_13]

   // Bus decode; writes land at the edge where pready is seen high
   assign ofs = 12'(paddr_i);
   assign acc = psel_i & penable_i & ~q.rsp.pready;
   assign wr_go = psel_i & penable_i & pwrite_i & q.rsp.pready & ~q.rsp.pslverr;
   assign preload_wr = wr_go & (ofs == `PMA_OFS_PRELOAD);
   assign erase_wr = wr_go & (ofs == `PMA_OFS_CTRL) & pwdata_i[`PMA_CTRL_ERASE];
   assign tsel_ok = (q.term_sel < `PMA_TSEL_W'(`PMA_NTERM));

   // Next state
   always_comb
   begin
      d = q;
      // Three-stage pin capture; a change counts once stages two and three agree
      d.sy1 = pin_raw;
      d.sy2 = q.sy1;
      d.sy3 = q.sy2;
      for (int i = 0; i < `PMA_NSIG; i++)
      begin
         if (q.sy2[i] == q.sy3[i])
         begin
            d.filt[i] = q.sy3[i];
         end
      end
      d.clk_prev = q.filt[8];

      // Cell registers: async term beats preload, preload beats clock
      if (ar_t)
      begin
         d.cell_reg = '0; // [RULE_23] [RULE_04]
      end
      else if (preload_wr)
      begin
         d.cell_reg = pwdata_i[`PMA_NCELL-1:0]; // [RULE_16]
      end
      else if (clk_edge)
      begin
         if (sp_t)
         begin
            d.cell_reg = '1; // [RULE_23] [RULE_04]
         end
         else
         begin
            d.cell_reg = sum; // [RULE_14] [RULE_21]
         end
      end

      // Pins are registered; registered cells show their flip-flop
      for (int i = 0; i < `PMA_NCELL; i++)
      begin
         d.pin_o[i] = reg_mode[i] ? d.cell_reg[i] : sum[i];
      end
      d.pin_oe = oe_nx;

      // Bus answer: one wait state, then pready for exactly one cycle
      d.rsp.pready = acc;
      d.rsp.pslverr = 1'h0;
      d.rsp.prdata = '0;
      if (acc)
      begin
         d.rsp.pslverr = (ofs[1:0] != 2'h0);
         if (ofs == `PMA_OFS_CTRL)
         begin
            d.rsp.prdata[`PMA_CTRL_GLOB] = q.glob & ~q.secure; // [RULE_17]
            d.rsp.prdata[`PMA_CTRL_SECURE] = q.secure;
         end
         else if (ofs == `PMA_OFS_MODE)
         begin
            // Configuration reads zero while secured
            if (!q.secure) // [RULE_17]
            begin
               d.rsp.prdata[`PMA_MODE_A_LSB +: `PMA_NCELL] = q.mode_a;
               d.rsp.prdata[`PMA_MODE_B_LSB +: `PMA_NCELL] = q.mode_b;
               d.rsp.prdata[`PMA_POL_LSB +: `PMA_NCELL] = q.pol;
            end
         end
         else if (ofs == `PMA_OFS_TSEL)
         begin
            d.rsp.prdata[`PMA_TSEL_W-1:0] = q.term_sel;
         end
         else if (ofs == `PMA_OFS_TLO)
         begin
            if (!q.secure && tsel_ok) // [RULE_17]
            begin
               d.rsp.prdata = q.fuse[q.term_sel][31:0];
            end
         end
         else if (ofs == `PMA_OFS_THI)
         begin
            if (!q.secure && tsel_ok) // [RULE_17]
            begin
               d.rsp.prdata[`PMA_NCOL-33:0] = q.fuse[q.term_sel][`PMA_NCOL-1:32];
            end
         end
         else if (ofs == `PMA_OFS_STATUS)
         begin
            d.rsp.prdata[23:0] = {q.pin_oe, q.pin_o, q.cell_reg};
         end
         else if (ofs != `PMA_OFS_PRELOAD)
         begin
            d.rsp.pslverr = 1'h1;
         end
      end

      // Register writes
      if (wr_go)
      begin
         if (ofs == `PMA_OFS_CTRL)
         begin
            d.glob = pwdata_i[`PMA_CTRL_GLOB]; // [RULE_11] [RULE_13]
            d.secure = q.secure | pwdata_i[`PMA_CTRL_SECURE]; // [RULE_17]
         end
         else if (ofs == `PMA_OFS_MODE)
         begin
            d.mode_a = pwdata_i[`PMA_MODE_A_LSB +: `PMA_NCELL]; // [RULE_05]
            d.mode_b = pwdata_i[`PMA_MODE_B_LSB +: `PMA_NCELL]; // [RULE_05]
            d.pol = pwdata_i[`PMA_POL_LSB +: `PMA_NCELL]; // [RULE_06]
         end
         else if (ofs == `PMA_OFS_TSEL)
         begin
            d.term_sel = pwdata_i[`PMA_TSEL_W-1:0];
         end
         else if (ofs == `PMA_OFS_TLO && tsel_ok)
         begin
            d.fuse[q.term_sel][31:0] = pwdata_i;
         end
         else if (ofs == `PMA_OFS_THI && tsel_ok)
         begin
            d.fuse[q.term_sel][`PMA_NCOL-1:32] = pwdata_i[`PMA_NCOL-33:0];
         end
      end

      // Erase returns the whole configuration to its unprogrammed form
      if (erase_wr)
      begin
         d.fuse = '1; // [RULE_18]
         d.mode_a = `PMA_MODE_RST; // [RULE_19]
         d.mode_b = `PMA_MODE_RST; // [RULE_19]
         d.pol = `PMA_POL_RST; // [RULE_18]
         d.glob = `PMA_GLOB_RST; // [RULE_18]
         d.secure = 1'h0;
      end
   end

   // State register; reset gives the unprogrammed, cleared device
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '0; // [RULE_15]
         q.fuse <= '1; // [RULE_18]
         q.pol <= `PMA_POL_RST; // [RULE_18]
         q.glob <= `PMA_GLOB_RST; // [RULE_18]
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs come straight from the state register
   assign prdata_o = q.rsp.prdata;
   assign pready_o = q.rsp.pready;
   assign pslverr_o = q.rsp.pslverr;
   assign cell_pin_o = q.pin_o;
   assign cell_pin_oe_o = q.pin_oe;

   // Checks next to the logic
   property p_ar_clear;
      @(posedge mclk_i) disable iff (rst_i)
      ar_t |=> (q.cell_reg == '0);
   endproperty
   a_ar_clear: assert property (p_ar_clear) // [RULE_23]
      else $error("async reset term did not clear cell registers");

   property p_preset;
      @(posedge mclk_i) disable iff (rst_i)
      (clk_edge && sp_t && !ar_t && !preload_wr) |=> (q.cell_reg == '1);
   endproperty
   a_preset: assert property (p_preset) // [RULE_04]
      else $error("sync preset did not set cell registers");

   property p_hold;
      @(posedge mclk_i) disable iff (rst_i)
      (!clk_edge && !ar_t && !preload_wr) |=> $stable(q.cell_reg);
   endproperty
   a_hold: assert property (p_hold) // [RULE_21]
      else $error("cell register changed without a clock edge");

   property p_capture;
      @(posedge mclk_i) disable iff (rst_i)
      (clk_edge && !sp_t && !ar_t && !preload_wr) |=> (q.cell_reg == $past(sum));
   endproperty
   a_capture: assert property (p_capture) // [RULE_14]
      else $error("cell register did not take the cell sum");

   property p_preload;
      @(posedge mclk_i) disable iff (rst_i)
      (preload_wr && !ar_t) |=> (q.cell_reg == $past(pwdata_i[7:0]));
   endproperty
   a_preload: assert property (p_preload) // [RULE_16]
      else $error("preload value not loaded");

   // Cell 3 is the one set up as a register; cell 0 only ever drives as fixed output
   property p_reg_oe;
      @(posedge mclk_i) disable iff (rst_i)
      reg_mode[3] |=> (cell_pin_oe_o[3] == ($past(~q.glob) & ~$past(q.filt[9])));
   endproperty
   a_reg_oe: assert property (p_reg_oe) // [RULE_12]
      else $error("registered cell enable not from shared pin");

   // Cell 2 has a live direction term, so a stuck enable would show here
   property p_bidir_oe;
      @(posedge mclk_i) disable iff (rst_i)
      ({q.mode_a[2], q.mode_b[2]} == `PMA_MODE_BIDIR) |=> (cell_pin_oe_o[2] == $past(dir[2]));
   endproperty
   a_bidir_oe: assert property (p_bidir_oe) // [RULE_09]
      else $error("bidirectional enable not from direction term");

   property p_secure_read;
      @(posedge mclk_i) disable iff (rst_i)
      (acc && !pwrite_i && q.secure && (ofs == `PMA_OFS_MODE || ofs == `PMA_OFS_TLO ||
         ofs == `PMA_OFS_THI)) |=> (pready_o && prdata_o == '0);
   endproperty
   a_secure_read: assert property (p_secure_read) // [RULE_17]
      else $error("array readable while secured");

   property p_erase;
      @(posedge mclk_i) disable iff (rst_i)
      erase_wr |=> (q.pol == `PMA_POL_RST && q.glob && q.mode_a == '0 && q.mode_b == '0) ##1
         (term == '0 && cell_pin_oe_o == '0);
   endproperty
   a_erase: assert property (p_erase) // [RULE_18]
      else $error("erase did not restore the unprogrammed state");

   property p_ready;
      @(posedge mclk_i) disable iff (rst_i)
      acc |=> pready_o ##1 !pready_o;
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready not a single cycle after one wait");

endmodule
`default_nettype wire

// [sim/pma_board.sv]
`timescale 1ns/10ps
`default_nettype none
module pma_board
(
   input wire logic mclk_i,
   input wire logic [7:0] drv_i,
   input wire logic [7:0] drv_oe_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] wire_o
);
   logic [7:0] float_q = 8'h55;
   // Undriven pins wander, so a stale level is never read as real
   always_ff @(posedge mclk_i)
   begin
      float_q <= ~float_q;
   end
   // Wire level: cell driver first, then board driver, else floating
   always_comb
   begin
      wire_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_en_i & ext_val_i);
      wire_o = wire_o | (~drv_oe_i & ~ext_en_i & float_q);
   end
endmodule
`default_nettype wire

// [sim/pma_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pma_params.svh"
module pma_bench;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, clkp = 1'b0, oen = 1'b1, pol;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, err;
   logic [7:0] ded = 8'h00, ext_en = 8'h00, ext_val = 8'h00, pin_i, pin_o, pin_oe;
   logic [2:0] exp3;
   int fails = 0, cmp_count = 0, cyc = 0;
   pma_top #(.ADDR_W(12)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .shared_clk_pin_i(clkp), .shared_oe_n_pin_i(oen), .ded_pin_i(ded),
      .cell_pin_i(pin_i), .cell_pin_o(pin_o), .cell_pin_oe_o(pin_oe));
   pma_board board (.mclk_i(mclk_i), .drv_i(pin_o), .drv_oe_i(pin_oe),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .wire_o(pin_i));
   // Free-running system clock
   initial
   begin
      forever #4 mclk_i = ~mclk_i;
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // APB master: setup, access, hold until pready seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      @(posedge mclk_i);
      // No wait limit here; the hang guard ends a stuck transfer
      while (pready !== 1'b1)
      begin
         @(posedge mclk_i);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      chk("wait states", 32'(n), 32'h00000001);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(name, rd, exp);
   endtask
   // One product term: select, then both fuse words
   task automatic prog_term(input logic [6:0] idx, input logic [31:0] lo);
      wr(`PMA_OFS_TSEL, 32'(idx));
      wr(`PMA_OFS_TLO, lo);
      wr(`PMA_OFS_THI, 32'h00000000);
   endtask
   // Pin changes need five clocks through the input filter
   task automatic settle();
      repeat (8) @(posedge mclk_i);
   endtask
   task automatic clk_edge();
      clkp <= 1'b0;
      settle();
      clkp <= 1'b1;
      settle();
   endtask
   // Expected {bidir enable of cell 2, cell 1, cell 0}; shared clock pin acts as input
   function automatic logic [2:0] exp_comb(input logic [7:0] d, input logic [7:0] e,
      input logic p, input logic c);
      return {d[1] & c, e[4], d[0] ^ p};
   endfunction
   // Main sequence
   initial
   begin
      void'($urandom(32'h84E7B442));
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      rdchk("ctrl reset", `PMA_OFS_CTRL, 32'h00000001);
      rdchk("mode reset", `PMA_OFS_MODE, 32'h00FF0000);
      rdchk("status reset", `PMA_OFS_STATUS, 32'h0000FF00);
      apb(1'b0, 12'h01C, 32'h00000000);
      chk("unmapped", {rd[30:0], err}, 32'h00000001);
      apb(1'b0, 12'h006, 32'h00000000);
      chk("unaligned", 32'(err), 32'h00000001);
      $display("test reset done");
      // Cell 0 out of ded 0, cell 1 from fixed-input cell 4, cell 2 bidir
      prog_term(7'h00, 32'h00000001);
      prog_term(7'h09, 32'h10200000);
      prog_term(7'h1A, 32'h00010004);
      ext_en <= 8'h10;
      for (int p = 0; p < 2; p++)
      begin
         pol = p[0];
         wr(`PMA_OFS_MODE, {15'h0000, pol, 16'h1003});
         repeat (6)
         begin
            ded <= 8'($urandom);
            ext_val <= 8'($urandom);
            oen <= 1'($urandom);
            clkp <= 1'($urandom);
            settle();
            exp3 = exp_comb(ded, ext_val, pol, clkp);
            chk("cell 0", 32'(pin_o[0]), 32'(exp3[0]));
            chk("cell 1", 32'(pin_o[1]), 32'(exp3[1]));
            chk("cell 2 oe", 32'(pin_oe[2]), 32'(exp3[2]));
            chk("fixed oe", 32'({pin_oe[4], pin_oe[1:0]}), 32'h00000003);
         end
      end
      $display("test combinational done");
      // Cell 3 registered on the shared clock pin
      wr(`PMA_OFS_CTRL, 32'h00000000);
      prog_term(7'h1B, 32'h00000001);
      wr(`PMA_OFS_MODE, 32'h0000180B);
      repeat (4)
      begin
         ded <= 8'($urandom);
         oen <= 1'($urandom);
         clk_edge();
         chk("reg oe", 32'(pin_oe[3]), 32'({~oen}));
         chk("reg", 32'(pin_o[3]), 32'(ded[0]));
         ded <= ~ded;
         settle();
         chk("reg hold", 32'(pin_o[3]), 32'({~ded[0]}));
      end
      for (int v = 0; v < 2; v++)
      begin
         wr(`PMA_OFS_PRELOAD, v[0] ? 32'h00000008 : 32'h00000000);
         apb(1'b0, `PMA_OFS_STATUS, 32'h00000000);
         chk("preload", 32'(rd[3]), 32'(v[0]));
      end
      prog_term(7'h48, 32'h00000004);
      ded <= 8'h02;
      clk_edge();
      chk("sync preset", 32'(pin_o[3]), 32'h00000001);
      prog_term(7'h49, 32'h00000010);
      ded <= 8'h06;
      settle();
      chk("async reset", 32'(pin_o[3]), 32'h00000000);
      ded <= 8'h00;
      $display("test registered done");
      // Security fuse, then erase back to the unprogrammed state
      rdchk("term lo", `PMA_OFS_TLO, 32'h00000010);
      wr(`PMA_OFS_CTRL, 32'h00000002);
      rdchk("secure mode", `PMA_OFS_MODE, 32'h00000000);
      rdchk("secure term", `PMA_OFS_TLO, 32'h00000000);
      wr(`PMA_OFS_CTRL, 32'h00000004);
      rdchk("erase mode", `PMA_OFS_MODE, 32'h00FF0000);
      rdchk("erase ctrl", `PMA_OFS_CTRL, 32'h00000001);
      settle();
      chk("erase oe", 32'(pin_oe), 32'h00000000);
      $display("test security done");
      complete_run();
   end
endmodule
`default_nettype wire
